// ==== adc_sel_pkg.sv ====
// ==========================================================================
// Shared constants for the converter selection and sleep-start control.
package adc_sel_pkg;

	// ======================================================================
	// Register map, byte addresses on the AXI4-Lite port.
	localparam int         ADDR_W     = 4;
	localparam logic [3:0] OFF_SEL    = 4'h0;
	localparam logic [3:0] OFF_CTRL   = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h8;
	localparam logic [3:0] OFF_ACTIVE = 4'hc;

	// ======================================================================
	// Field layout of the selection byte.
	localparam int CHAN_W      = 5;
	localparam int REF_W       = 2;
	localparam int SEL_CHAN_LSB = 0;
	localparam int SEL_REF_LSB  = 6;

	// Control and status bit positions.
	localparam int CTRL_EN    = 0;
	localparam int CTRL_START = 1;
	localparam int CTRL_ATE   = 2;
	localparam int CTRL_IE    = 3;
	localparam int CTRL_TSRC  = 4;
	localparam int STAT_DONE  = 0;
	localparam int STAT_BUSY  = 1;
	localparam int STAT_FIRST = 2;

	// ======================================================================
	// Values after reset.
	localparam logic [CHAN_W-1:0] CHAN_RST = 5'h00;
	localparam logic [REF_W-1:0]  REF_RST  = 2'h0;

	// Reference codes: pin, supply, reserved, internal 1.1 V.
	localparam logic [REF_W-1:0] REF_EXT_PIN = 2'h0;
	localparam logic [REF_W-1:0] REF_SUPPLY  = 2'h1;
	localparam logic [REF_W-1:0] REF_RSVD    = 2'h2;
	localparam logic [REF_W-1:0] REF_INT_1V1 = 2'h3;
	localparam logic [9:0]       FULL_SCALE  = 10'h3ff;

	// Sleep mode codes presented by the power manager.
	localparam logic [2:0] SLEEP_IDLE  = 3'h0;
	localparam logic [2:0] SLEEP_NOISE = 3'h1;

	// ======================================================================
	// Conversion lengths in converter clock cycles.
	localparam int         CNT_W         = 5;
	localparam logic [4:0] CONV_CYC_NORM = 5'h0d;
	localparam logic [4:0] CONV_CYC_FIRST = 5'h19;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} conv_state_t;

endpackage

// ==== sel_buffer.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Active selection register fed from the software-written temporary copy.
module sel_buffer import adc_sel_pkg::*; #(
	parameter int W = 7
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Temporary selection and copy permission.
	input  wire logic [W-1:0] temp,
	input  wire logic         copy_en,
	// Selection applied to the multiplexer.
	output logic      [W-1:0] active
);

	logic [W-1:0] active_q;

	// Copy while permitted, otherwise hold the frozen value.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			active_q <= '0;
		end else if (copy_en) begin
			active_q <= temp;
		end
	end

	assign active = active_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_track;
		copy_en |=> active == $past(temp);
	endproperty
	a_track: assert property (p_track)
		else $error("active selection did not follow temporary");

	property p_freeze;
		!copy_en |=> $stable(active);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("active selection changed while frozen");

endmodule

// ==== conv_timer.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Counts the converter clock cycles of one conversion.
module conv_timer import adc_sel_pkg::*; (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_b,
	// Launch, length choice and abort.
	input  wire logic go,
	input  wire logic long_conv,
	input  wire logic abort,
	// Progress.
	output logic      busy,
	output logic      last
);

	conv_state_t      state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] len;

	assign len  = long_conv ? CONV_CYC_FIRST : CONV_CYC_NORM;
	assign busy = (state_q == ST_RUN);
	assign last = busy && (cnt_q == 5'h01);

	// Load on launch, count down, reload when relaunched in the last cycle.
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			ST_IDLE: begin
				if (go && !abort) begin
					state_d = ST_RUN;
					cnt_d   = len;
				end
			end
			ST_RUN: begin
				if (abort) begin
					state_d = ST_IDLE;
				end else if (last) begin
					state_d = go ? ST_RUN : ST_IDLE;
					cnt_d   = len;
				end else begin
					cnt_d = cnt_q - 5'h01;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Length actually spent, kept only for checking.
	logic [CNT_W-1:0] run_len_q;
	logic [CNT_W-1:0] exp_len_q;
	wire              launch = go && !abort && (!busy || last);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			run_len_q <= '0;
			exp_len_q <= '0;
		end else if (launch) begin
			run_len_q <= 5'h01;
			exp_len_q <= len;
		end else if (busy) begin
			run_len_q <= run_len_q + 5'h01;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_length;
		last |-> run_len_q == exp_len_q;
	endproperty
	a_length: assert property (p_length)
		else $error("conversion length differs from 13 or 25 cycles");

endmodule

// ==== adc_select_ctrl.sv ====
`timescale 1ns/1ps
// ==========================================================================
module adc_select_ctrl import adc_sel_pkg::*; (
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              rst_b,
	// AXI4-Lite write address and data.
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// AXI4-Lite write response.
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read.
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Trigger and power manager.
	input  wire logic              trig_in,
	input  wire logic [2:0]        sleep_mode,
	input  wire logic              cpu_halted,
	// Converter core side.
	output logic [CHAN_W-1:0]      active_channel,
	output logic [REF_W-1:0]       active_ref,
	output logic                   conv_start,
	output logic                   conv_busy,
	// Completion request and wake.
	output logic                   conv_irq,
	output logic                   cpu_wake
);

	// ======================================================================
	// Bus write side: address and data are taken in either order.
	logic              aw_held_q;
	logic              w_held_q;
	logic [ADDR_W-1:0] waddr_q;
	logic [7:0]        wbyte_q;
	logic              wlane_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;

	wire aw_take = awvalid && awready;
	wire w_take  = wvalid && wready;
	wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
	wire wr_lane = wr_fire && wlane_q;

	assign awready = !aw_held_q;
	assign wready  = !w_held_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;

	// Decode of the stored write address.
	wire wr_hit_sel  = (waddr_q == OFF_SEL);
	wire wr_hit_ctrl = (waddr_q == OFF_CTRL);
	wire wr_hit_stat = (waddr_q == OFF_STATUS);
	wire wr_hit_act  = (waddr_q == OFF_ACTIVE);
	wire wr_mapped   = wr_hit_sel || wr_hit_ctrl || wr_hit_stat || wr_hit_act;
	wire wr_sel      = wr_lane && wr_hit_sel;
	wire wr_ctrl     = wr_lane && wr_hit_ctrl;
	wire wr_stat     = wr_lane && wr_hit_stat;

	// Hold address and data until both are present, then answer.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			waddr_q   <= '0;
			wbyte_q   <= 8'h00;
			wlane_q   <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held_q <= 1'b1;
				waddr_q   <= awaddr;
			end
			if (w_take) begin
				w_held_q <= 1'b1;
				wbyte_q  <= wdata[7:0];
				wlane_q  <= wstrb[0];
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Software-visible control state.
	logic [CHAN_W-1:0] temp_chan_q;
	logic [REF_W-1:0]  temp_ref_q;
	logic              enable_q;
	logic              start_q;
	logic              ate_q;
	logic              ie_q;
	logic              tsrc_q;
	logic              done_q;
	logic              first_q;
	logic              trig_prev_q;
	logic              launched_q;

	// Temporary selection is written freely, whatever the converter does.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			temp_chan_q <= CHAN_RST;
			temp_ref_q  <= REF_RST;
		end else if (wr_sel) begin
			temp_chan_q <= wbyte_q[SEL_CHAN_LSB +: CHAN_W];
			temp_ref_q  <= wbyte_q[SEL_REF_LSB +: REF_W];
		end
	end

	// Mode bits; enable changes only by a bus write, never by sleep.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			enable_q <= 1'b0;
			ate_q    <= 1'b0;
			ie_q     <= 1'b0;
			tsrc_q   <= 1'b0;
		end else if (wr_ctrl) begin
			enable_q <= wbyte_q[CTRL_EN];
			ate_q    <= wbyte_q[CTRL_ATE];
			ie_q     <= wbyte_q[CTRL_IE];
			tsrc_q   <= wbyte_q[CTRL_TSRC];
		end
	end

	// ======================================================================
	// Launch decisions.
	logic busy;
	logic last;

	wire free_run   = ate_q && tsrc_q;
	wire trig_level = tsrc_q ? done_q : trig_in;
	wire trig_edge  = trig_level && !trig_prev_q;
	wire sleep_ok   = (sleep_mode == SLEEP_IDLE) ||
	                  (sleep_mode == SLEEP_NOISE);
	wire sw_go      = start_q && !busy;
	wire auto_go    = ate_q && !tsrc_q && trig_edge && !busy;
	wire sleep_go   = sleep_ok && cpu_halted && !launched_q && !busy;
	wire rerun_go   = free_run && last;
	wire go         = enable_q && (sw_go || auto_go || sleep_go || rerun_go);
	wire abort      = !enable_q;
	wire copy_en    = !busy || last;
	wire done_evt   = last && enable_q;

	assign conv_start = go && (!busy || last);
	assign conv_busy  = busy;

	// Start bit: set by write or any launch, cleared when the run ends.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			start_q <= 1'b0;
		end else if ((wr_ctrl && wbyte_q[CTRL_START]) || conv_start) begin
			start_q <= 1'b1;
		end else if (abort || (done_evt && !rerun_go)) begin
			start_q <= 1'b0;
		end
	end

	// Done flag: hardware set wins over a write-one clear.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done_q <= 1'b0;
		end else if (done_evt) begin
			done_q <= 1'b1;
		end else if (wr_stat && wbyte_q[STAT_DONE]) begin
			done_q <= 1'b0;
		end
	end

	// First-conversion mark re-arms whenever the converter is off.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			first_q <= 1'b1;
		end else if (!enable_q) begin
			first_q <= 1'b1;
		end else if (conv_start) begin
			first_q <= 1'b0;
		end
	end

	// Trigger edge memory and one launch per sleep period.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			trig_prev_q <= 1'b0;
			launched_q  <= 1'b0;
		end else begin
			trig_prev_q <= trig_level;
			if (!cpu_halted) begin
				launched_q <= 1'b0;
			end else if (sleep_go && enable_q) begin
				launched_q <= 1'b1;
			end
		end
	end

	// ======================================================================
	// Conversion timing and selection buffer.
	conv_timer u_timer (
		.clk       (clk),
		.rst_b     (rst_b),
		.go        (go),
		.long_conv (first_q),
		.abort     (abort),
		.busy      (busy),
		.last      (last)
	);

	sel_buffer #(
		.W (CHAN_W + REF_W)
	) u_sel (
		.clk     (clk),
		.rst_b   (rst_b),
		.temp    ({temp_ref_q, temp_chan_q}),
		.copy_en (copy_en),
		.active  ({active_ref, active_channel})
	);

	// Completion request stays up until cleared; it wakes a halted CPU.
	assign conv_irq = done_q && ie_q;
	assign cpu_wake = conv_irq && cpu_halted;

	// ======================================================================
	// Bus read side.
	logic        rvalid_q;
	logic [7:0]  rbyte_q;
	logic [1:0]  rresp_q;
	logic [7:0]  rd_byte;

	wire ar_take     = arvalid && arready;
	wire rd_hit_sel  = (araddr == OFF_SEL);
	wire rd_hit_ctrl = (araddr == OFF_CTRL);
	wire rd_hit_stat = (araddr == OFF_STATUS);
	wire rd_hit_act  = (araddr == OFF_ACTIVE);
	wire rd_mapped   = rd_hit_sel || rd_hit_ctrl || rd_hit_stat || rd_hit_act;

	// Read data selection; reserved bits read zero.
	wire [7:0] sel_byte  = {temp_ref_q, 1'b0, temp_chan_q};
	wire [7:0] act_byte  = {active_ref, 1'b0, active_channel};
	wire [7:0] ctrl_byte = {3'h0, tsrc_q, ie_q, ate_q, start_q, enable_q};
	wire [7:0] stat_byte = {5'h00, first_q, busy, done_q};

	assign rd_byte = rd_hit_sel  ? sel_byte  :
	                 rd_hit_ctrl ? ctrl_byte :
	                 rd_hit_stat ? stat_byte :
	                 rd_hit_act  ? act_byte  : 8'h00;

	assign arready = !rvalid_q;
	assign rvalid  = rvalid_q;
	assign rdata   = {24'h000000, rbyte_q};
	assign rresp   = rresp_q;

	// Capture the read answer on the address handshake.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_q <= 1'b0;
			rbyte_q  <= 8'h00;
			rresp_q  <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rbyte_q  <= rd_byte;
			rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ======================================================================
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_start_write;
		wr_ctrl && wbyte_q[CTRL_START] && wbyte_q[CTRL_EN] && enable_q
		&& !busy;
	endsequence

	property p_start_edge;
		s_start_write |=> !busy ##1 busy;
	endproperty
	a_start_edge: assert property (p_start_edge)
		else $error("start write did not launch at the next edge");

	property p_start_reads_one;
		busy |-> start_q;
	endproperty
	a_start_reads_one: assert property (p_start_reads_one)
		else $error("start bit low during conversion");

	property p_start_clears;
		done_evt && !rerun_go && !(wr_ctrl && wbyte_q[CTRL_START])
		|=> !start_q;
	endproperty
	a_start_clears: assert property (p_start_clears)
		else $error("start bit not cleared at completion");

	property p_flag_after_last;
		$rose(done_q) |-> $past(last);
	endproperty
	a_flag_after_last: assert property (p_flag_after_last)
		else $error("done flag rose without a final cycle");

	property p_copy_in_last;
		done_evt |=> act_byte == $past(sel_byte);
	endproperty
	a_copy_in_last: assert property (p_copy_in_last)
		else $error("selection not refreshed in final cycle");

	property p_free_run;
		last && free_run && enable_q |=> busy && active_channel ==
		$past(temp_chan_q);
	endproperty
	a_free_run: assert property (p_free_run)
		else $error("free running restart missed or used wrong channel");

	sequence s_sleep_launch;
		sleep_go && enable_q;
	endsequence

	property p_sleep_start;
		s_sleep_launch |=> busy ##0 launched_q;
	endproperty
	a_sleep_start: assert property (p_sleep_start)
		else $error("halted CPU in quiet sleep did not launch");

	property p_irq_on_done;
		done_evt && ie_q && !wr_ctrl |=> conv_irq ##0 (cpu_wake == cpu_halted);
	endproperty
	a_irq_on_done: assert property (p_irq_on_done)
		else $error("completion request or wake missing");

	property p_enable_kept;
		!wr_ctrl && enable_q |=> enable_q;
	endproperty
	a_enable_kept: assert property (p_enable_kept)
		else $error("enable cleared without a write");

endmodule

// ==== adc_core_model.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Converter core stand-in: notes the selection it samples and the length.
module adc_core_model import adc_sel_pkg::*; (
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              rst_b,
	// Control from the selection block.
	input  wire logic              conv_start,
	input  wire logic              conv_busy,
	input  wire logic [CHAN_W-1:0] active_channel,
	input  wire logic [REF_W-1:0]  active_ref,
	// One pulse per finished conversion.
	output logic                   fin,
	output logic [5:0]             fin_len,
	output logic [6:0]             fin_sel
);
	logic [5:0] n_q;
	logic [6:0] cap_q;

	// Counts busy edges; a start seen while busy closes the conversion.
	// The core drives no port pin, so nothing switches mid-conversion.
	// Results carry no analog value, so no settling wait or discard.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			n_q     <= 6'h00;
			cap_q   <= 7'h00;
			fin     <= 1'b0;
			fin_len <= 6'h00;
			fin_sel <= 7'h00;
		end else begin
			fin <= 1'b0;
			if (conv_busy && n_q == 6'h00)
				cap_q <= {active_ref, active_channel};
			if (conv_busy && !conv_start)
				n_q <= n_q + 6'h01;
			else if (conv_busy || n_q != 6'h00) begin
				fin     <= 1'b1;
				fin_len <= n_q + {5'h00, conv_busy};
				fin_sel <= cap_q;
				n_q     <= 6'h00;
			end
		end
	end
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the selection buffer and sleep-start control.
module testbench import adc_sel_pkg::*;;
	logic              clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, arready, rvalid;
	logic              trig_in, cpu_halted, conv_start, conv_busy;
	logic              conv_irq, cpu_wake, fin, rd_chk;
	logic [3:0]        awaddr, araddr;
	logic [2:0]        sleep_mode;
	logic [31:0]       wdata, rdata;
	logic [1:0]        bresp, rresp;
	logic [CHAN_W-1:0] active_channel;
	logic [REF_W-1:0]  active_ref;
	logic [5:0]        fin_len;
	logic [6:0]        fin_sel;
	logic [33:0]       bq[$];
	logic [33:0]       cq[$];
	int                mismatches, n_tests, nfin, cyc;

	// ======================================================================
	// Design and converter core.
	adc_select_ctrl i_dut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .trig_in(trig_in),
		.sleep_mode(sleep_mode), .cpu_halted(cpu_halted),
		.active_channel(active_channel), .active_ref(active_ref),
		.conv_start(conv_start), .conv_busy(conv_busy),
		.conv_irq(conv_irq), .cpu_wake(cpu_wake));
	adc_core_model i_core (.clk(clk), .rst_b(rst_b), .conv_start(conv_start),
		.conv_busy(conv_busy), .active_channel(active_channel),
		.active_ref(active_ref), .fin(fin), .fin_len(fin_len),
		.fin_sel(fin_sel));

	// Clock generator and hang guard.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			results();
		end
	end

	// ======================================================================
	// Helpers.
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [33:0] ce(input logic [5:0] l, input logic [7:0] s);
		return {21'h0, l, s[7:6], s[4:0]};
	endfunction
	function automatic logic [7:0] rs();
		logic [31:0] r;
		r = $urandom;
		return {r[7:6], 1'b0, r[4:0]};
	endfunction
	// Write with both channels offered together, each released when taken.
	task automatic wr(input logic [3:0] a, input logic [7:0] d,
			input logic [1:0] er);
		logic ta, tw, tb;
		bq.push_back({er, 32'h0});
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ta = awready;
			tw = wready;
			tb = bvalid;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		// Ready stays high, so a call never drops and raises it in one step.
	endtask
	task automatic rd(input logic [3:0] a, input logic [1:0] er,
			input logic [7:0] e);
		logic t, v;
		bq.push_back({er, 24'h0, e});
		rd_chk = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			t = arready;
			v = rvalid;
			@(posedge clk);
			if (t) arvalid <= 1'b0;
		end while (!v);
	endtask
	task automatic wait_fin(input int k);
		while (nfin < k) @(posedge clk);
		repeat (2) @(posedge clk);
	endtask

	// Monitor: takes the oldest note whenever a result appears.
	always @(negedge clk) begin
		if (bvalid && bready) chk({bresp, 32'h0}, bq.pop_front());
		if (rvalid && rready && rd_chk)
			chk({rresp, rdata}, bq.pop_front());
		if (fin) begin
			nfin++;
			chk(ce(fin_len, {fin_sel[6:5], 1'b0, fin_sel[4:0]}),
				cq.pop_front());
		end
	end

	// ======================================================================
	// Main sequence.
	initial begin
		logic [7:0] a, b;
		{mismatches, n_tests, nfin, cyc} = '0;
		{rst_b, awvalid, wvalid, bready, arvalid, rready, rd_chk} = '0;
		{trig_in, cpu_halted, awaddr, araddr, wdata} = '0;
		sleep_mode = 3'h7;
		void'($urandom(32'h6397ce56));
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(OFF_SEL, RESP_OKAY, 8'h00);
		rd(OFF_CTRL, RESP_OKAY, 8'h00);
		rd(OFF_STATUS, RESP_OKAY, 8'h04); // First run pending.
		rd(OFF_ACTIVE, RESP_OKAY, 8'h00);
		rd(4'h2, RESP_SLVERR, 8'h00);
		wr(4'h6, 8'h01, RESP_SLVERR);
		rd(OFF_CTRL, RESP_OKAY, 8'h00);
		$display("test reset and map done");
		// Every reference code passes straight through while idle.
		for (int i = 0; i < 4; i++) begin
			a = rs();
			a[7:6] = i[1:0];
			wr(OFF_SEL, a, RESP_OKAY); // Temporary copy.
			rd(OFF_ACTIVE, RESP_OKAY, a); // Copied while idle.
		end
		wr(OFF_SEL, 8'hff, RESP_OKAY);
		rd(OFF_SEL, RESP_OKAY, 8'hdf); // The spare bit reads zero.
		$display("test idle copy done");
		// Long first conversion, frozen selection, short second one.
		a = rs();
		b = rs();
		wr(OFF_SEL, a, RESP_OKAY);
		wr(OFF_CTRL, 8'h01, RESP_OKAY);
		cq.push_back(ce(6'd25, a)); // First after enable.
		cq.push_back(ce(6'd13, b)); // Written while busy, used next.
		wr(OFF_CTRL, 8'h03, RESP_OKAY); // Starts at the next edge.
		@(posedge clk); // One cycle before touching the selection.
		wr(OFF_SEL, b, RESP_OKAY);
		rd(OFF_ACTIVE, RESP_OKAY, a); // Held during sampling.
		rd(OFF_CTRL, RESP_OKAY, 8'h03); // Start reads one.
		wait_fin(1);
		rd(OFF_CTRL, RESP_OKAY, 8'h01); // Cleared at the end.
		rd(OFF_ACTIVE, RESP_OKAY, b); // Copying resumed.
		rd(OFF_STATUS, RESP_OKAY, 8'h01); // Flag up after final cycle.
		wr(OFF_CTRL, 8'h03, RESP_OKAY);
		wait_fin(2); // Normal length.
		wr(OFF_STATUS, 8'h01, RESP_OKAY);
		$display("test single conversion done");
		// Free running: next result old channel, the one after it the new.
		a = rs();
		b = rs();
		wr(OFF_SEL, a, RESP_OKAY);
		cq.push_back(ce(6'd13, a));
		cq.push_back(ce(6'd13, a));
		cq.push_back(ce(6'd13, b));
		wr(OFF_CTRL, 8'h17, RESP_OKAY);
		wait_fin(3);
		wr(OFF_SEL, b, RESP_OKAY); // Change inside a safe window.
		wait_fin(4);
		wr(OFF_CTRL, 8'h01, RESP_OKAY);
		wait_fin(5);
		repeat (30) @(posedge clk);
		chk(34'(nfin), 34'd5); // Stops once auto-trigger is off.
		wr(OFF_STATUS, 8'h01, RESP_OKAY);
		$display("test free running done");
		// External trigger edge.
		a = rs();
		wr(OFF_SEL, a, RESP_OKAY); // Written with auto-trigger off.
		cq.push_back(ce(6'd13, a)); // Next conversion uses it.
		wr(OFF_CTRL, 8'h05, RESP_OKAY);
		trig_in <= 1'b1;
		// Held past the end: a level still high must not relaunch.
		repeat (20) @(posedge clk);
		trig_in <= 1'b0;
		wait_fin(6);
		wr(OFF_STATUS, 8'h01, RESP_OKAY);
		$display("test trigger done");
		// Sleep start: stay halted, then an early wake by another source.
		wr(OFF_CTRL, 8'h09, RESP_OKAY); // Enabled, single, irq on.
		for (int m = 0; m < 2; m++) begin
			cq.push_back(ce(6'd13, a));
			sleep_mode <= m[2:0];
			cpu_halted <= 1'b1; // Halted CPU starts it.
			if (m == 1) begin
				repeat (5) @(posedge clk);
				cpu_halted <= 1'b0;
			end
			wait_fin(7 + m);
			chk({32'h0, conv_irq, cpu_wake}, m ? 34'h2 : 34'h3);
			cpu_halted <= 1'b0;
			wr(OFF_STATUS, 8'h01, RESP_OKAY);
		end
		sleep_mode <= 3'h2;
		cpu_halted <= 1'b1;
		repeat (40) @(posedge clk);
		chk(34'(nfin), 34'd8); // No launch in sleep mode 2.
		rd(OFF_CTRL, RESP_OKAY, 8'h09); // Enable left alone.
		// No differential run follows this halt, so no enable toggle.
		cpu_halted <= 1'b0;
		$display("test sleep start done");
		results();
	end
endmodule
